// File: rtl/unb_pkg.sv
package unb_pkg;

    // register port geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    // register offsets
    localparam logic [ADDR_W-1:0] REG_CTRL  = 4'h0;
    localparam logic [ADDR_W-1:0] REG_BUF   = 4'h1;
    localparam logic [ADDR_W-1:0] REG_PWR   = 4'h2;
    localparam logic [ADDR_W-1:0] REG_BAUD  = 4'h3;
    localparam logic [ADDR_W-1:0] REG_T1    = 4'h4;
    localparam logic [ADDR_W-1:0] REG_GENL  = 4'h5;
    localparam logic [ADDR_W-1:0] REG_GENH  = 4'h6;
    localparam logic [ADDR_W-1:0] REG_ISTAT = 4'h7;
    localparam logic [ADDR_W-1:0] REG_IMASK = 4'h8;

    // serial_control field positions
    localparam int CTRL_RXDONE = 0;
    localparam int CTRL_TXDONE = 1;
    localparam int CTRL_RXNINE = 2;
    localparam int CTRL_TXNINE = 3;
    localparam int CTRL_RXEN   = 4;
    localparam int CTRL_MPF    = 5;
    localparam int CTRL_MODE3  = 6;
    // power_control and baud source fields
    localparam int PWR_DOUBLE  = 7;
    localparam int BAUD_GEN    = 0;
    // interrupt status / mask fields
    localparam int INT_TX      = 0;
    localparam int INT_RX      = 1;

    // reset values and timing counts
    localparam logic [9:0] GEN_RELOAD_RST = 10'h3D9;
    localparam logic [9:0] GEN_LAST       = 10'h3FF;
    localparam logic [7:0] T1_LAST        = 8'hFF;
    localparam logic [2:0] PRESCALE_LAST  = 3'h5;
    localparam logic [3:0] CNT_LAST       = 4'hF;
    localparam logic [3:0] SMP_A          = 4'h7;
    localparam logic [3:0] SMP_B          = 4'h8;
    localparam logic [3:0] SMP_C          = 4'h9;
    localparam logic [8:0] RX_PRELOAD     = 9'h1FF;
    localparam logic [7:0] TX_DONE_PATTERN = 8'h01;

    typedef enum logic [1:0] {RX_HUNT, RX_BITS, RX_HOLD} unb_rx_e;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } unb_bus_s;

    typedef struct packed {
        // software visible
        logic       rxDone;
        logic       txDone;
        logic       rxNinth;
        logic       txNinth;
        logic       rxEn;
        logic       mpFilter;
        logic       mode3;
        logic       baudDouble;
        logic       useGen;
        logic [7:0] t1Reload;
        logic [9:0] genReload;
        logic [1:0] intStat;
        logic [1:0] intMask;
        logic [7:0] rxBuf;
        // bit rate sources
        logic [2:0] pre6;
        logic [7:0] t1Cnt;
        logic [9:0] genCnt;
        logic       halfTog;
        // transmitter
        logic [8:0] txShift;
        logic       txReq;
        logic       txActive;
        logic       txDataEn;
        logic       txShifted;
        logic [3:0] txCnt;
        // receiver
        unb_rx_e    rxState;
        logic [3:0] rxCnt;
        logic [8:0] rxShift;
        logic       rxLast;
        logic       smpA;
        logic       smpB;
        logic       rxFirst;
        logic       sync1;
        logic       sync2;
        // registered outputs
        logic       txPin;
        logic       irq;
        logic [7:0] rdata;
    } unb_state_s;

endpackage : unb_pkg

// File: rtl/unb_serial.sv
//Contract
//- frame is start 0, eight data bits LSB first, ninth bit, stop 1
//- ninth bit sent from tx_ninth_bit; received ninth bit stored in rx_ninth_bit
//- mode 2 bit rate is osc/32, or osc/16 with baud_double
//- mode 3 bit rate from timer 1 overflows (osc/6) or baud generator
//- buffer write loads ninth bit, requests send; start waits for counter rollover
//- send_active drives start bit; data enabled next bit; first shift after
//- first shift inserts stop bit one at top; later shifts insert zeros
//- ninth bit out with stop beside: last shift, end send, set tx_done_flag
//- sample input at 16x; on falling edge reset counter, preload 1FF
//- sample at counter states 7, 8, 9; take two-of-three majority
//- first bit not zero: reset receiver and hunt again
//- 9-bit receive shifter; start bit at top triggers final shift and load
//- load only if rx_done_flag clear and filter off or ninth bit one
//- one bit time after final shift return to hunting
//- received stop bit affects neither buffer, ninth bit nor done flag
//
// Design decisions made here: the register offsets and the address-and-strobe port.
module unb_serial
(
    // clock and reset
    input  wire logic            core_clk,
    input  wire logic            rst,
    // register port
    input  wire unb_pkg::unb_bus_s busIn,
    output logic [unb_pkg::DATA_W-1:0] rdData,
    // serial line
    input  wire logic            serial_rx_pin,
    output logic                 serial_tx_pin,
    // interrupt
    output logic                 irq
);
    import unb_pkg::*;

    unb_state_s s_q;
    unb_state_s s_d;

    logic       genOvf;
    logic       t1Ovf;
    logic       rawTick;
    logic       tick16;
    logic       txRoll;
    logic       txDoneSet;
    logic       startDetect;
    logic       rxVoteNow;
    logic       rxVote;
    logic       rxFinal;
    logic       rxAccept;
    logic       falseStart;
    logic       ctrlWr;
    logic [1:0] intClr;

    always_comb begin
        s_d = s_q;

        // bit rate sources
        s_d.genCnt = (s_q.genCnt == GEN_LAST) ? s_q.genReload : s_q.genCnt + 10'h001;
        genOvf     = (s_q.genCnt == GEN_LAST);
        s_d.pre6   = (s_q.pre6 == PRESCALE_LAST) ? 3'h0 : s_q.pre6 + 3'h1;
        t1Ovf      = (s_q.pre6 == PRESCALE_LAST) && (s_q.t1Cnt == T1_LAST);
        if (s_q.pre6 == PRESCALE_LAST) begin
            s_d.t1Cnt = t1Ovf ? s_q.t1Reload : s_q.t1Cnt + 8'h01;
        end
        rawTick = s_q.mode3 ? (s_q.useGen ? genOvf : t1Ovf) : 1'b1;
        if (rawTick) begin
            s_d.halfTog = ~s_q.halfTog;
        end
        // without doubling, every other source tick feeds the 16x counters
        tick16 = rawTick && (s_q.baudDouble || s_q.halfTog);

        // transmitter
        txDoneSet = 1'b0;
        txRoll    = tick16 && (s_q.txCnt == CNT_LAST);
        if (tick16) begin
            s_d.txCnt = s_q.txCnt + 4'h1;
        end
        if (txRoll) begin
            if (!s_q.txActive) begin
                if (s_q.txReq) begin
                    s_d.txActive  = 1'b1;
                    s_d.txDataEn  = 1'b0;
                    s_d.txShifted = 1'b0;
                    s_d.txReq     = 1'b0;
                end
            end else if (!s_q.txDataEn) begin
                s_d.txDataEn = 1'b1;
            end else if (s_q.txShifted && (s_q.txShift[8:1] == TX_DONE_PATTERN)) begin
                s_d.txShift  = {1'b0, s_q.txShift[8:1]};
                s_d.txActive = 1'b0;
                s_d.txDataEn = 1'b0;
                txDoneSet    = 1'b1;
            end else begin
                s_d.txShift   = {~s_q.txShifted, s_q.txShift[8:1]};
                s_d.txShifted = 1'b1;
            end
        end

        // receiver
        s_d.sync1   = serial_rx_pin;
        s_d.sync2   = s_q.sync1;
        startDetect = 1'b0;
        rxFinal     = 1'b0;
        rxAccept    = 1'b0;
        falseStart  = 1'b0;
        rxVoteNow   = tick16 && (s_q.rxState != RX_HUNT) && (s_q.rxCnt == SMP_C);
        rxVote      = (s_q.smpA & s_q.smpB) | (s_q.smpA & s_q.sync2) | (s_q.smpB & s_q.sync2);
        if (tick16) begin
            s_d.rxLast = s_q.sync2;
            s_d.rxCnt  = s_q.rxCnt + 4'h1;
        end
        unique case (s_q.rxState)
            RX_HUNT: begin
                if (tick16 && s_q.rxEn && s_q.rxLast && !s_q.sync2) begin
                    startDetect = 1'b1;
                    s_d.rxCnt   = 4'h1;
                    s_d.rxShift = RX_PRELOAD;
                    s_d.rxFirst = 1'b1;
                    s_d.rxState = RX_BITS;
                end
            end
            RX_BITS: begin
                if (tick16 && (s_q.rxCnt == SMP_A)) begin
                    s_d.smpA = s_q.sync2;
                end
                if (tick16 && (s_q.rxCnt == SMP_B)) begin
                    s_d.smpB = s_q.sync2;
                end
                if (rxVoteNow) begin
                    s_d.rxFirst = 1'b0;
                    if (s_q.rxFirst && rxVote) begin
                        falseStart  = 1'b1;
                        s_d.rxState = RX_HUNT;
                    end else begin
                        s_d.rxShift = {s_q.rxShift[7:0], rxVote};
                        if (!s_q.rxShift[8]) begin
                            rxFinal     = 1'b1;
                            s_d.rxState = RX_HOLD;
                            // stop bit never sampled into the frame
                            rxAccept    = !s_q.rxDone && (!s_q.mpFilter || rxVote);
                        end
                    end
                end
            end
            RX_HOLD: begin
                if (rxVoteNow) begin
                    s_d.rxState = RX_HUNT;
                end
            end
            default: s_d.rxState = RX_HUNT;
        endcase
        if (rxAccept) begin
            s_d.rxNinth = rxVote;
            for (int i = 0; i < 8; i++) begin
                s_d.rxBuf[i] = s_q.rxShift[7-i];
            end
        end

        // register writes
        ctrlWr = busIn.wr && (busIn.addr == REG_CTRL);
        intClr = 2'h0;
        s_d.rxDone = s_q.rxDone | rxAccept;
        s_d.txDone = s_q.txDone | txDoneSet;
        if (busIn.wr) begin
            unique case (busIn.addr)
                REG_CTRL: begin
                    // set beats a simultaneous software clear
                    s_d.rxDone   = busIn.wdata[CTRL_RXDONE] | rxAccept;
                    s_d.txDone   = busIn.wdata[CTRL_TXDONE] | txDoneSet;
                    s_d.txNinth  = busIn.wdata[CTRL_TXNINE];
                    s_d.rxEn     = busIn.wdata[CTRL_RXEN];
                    s_d.mpFilter = busIn.wdata[CTRL_MPF];
                    s_d.mode3    = busIn.wdata[CTRL_MODE3];
                end
                REG_BUF: begin
                    s_d.txShift = {s_q.txNinth, busIn.wdata};
                    s_d.txReq   = 1'b1;
                end
                REG_PWR:   s_d.baudDouble = busIn.wdata[PWR_DOUBLE];
                REG_BAUD:  s_d.useGen = busIn.wdata[BAUD_GEN];
                REG_T1:    s_d.t1Reload = busIn.wdata;
                REG_GENL:  s_d.genReload[7:0] = busIn.wdata;
                REG_GENH:  s_d.genReload[9:8] = busIn.wdata[1:0];
                REG_ISTAT: intClr = busIn.wdata[1:0];
                REG_IMASK: s_d.intMask = busIn.wdata[1:0];
                default: ;
            endcase
        end
        s_d.intStat = (s_q.intStat & ~intClr) | {rxAccept, txDoneSet};

        // register reads, data valid the cycle after the strobe
        s_d.rdata = 8'h00;
        if (busIn.rd) begin
            unique case (busIn.addr)
                REG_CTRL:  s_d.rdata = {1'b0, s_q.mode3, s_q.mpFilter, s_q.rxEn,
                                        s_q.txNinth, s_q.rxNinth, s_q.txDone, s_q.rxDone};
                REG_BUF:   s_d.rdata = s_q.rxBuf;
                REG_PWR:   s_d.rdata = {s_q.baudDouble, 7'h00};
                REG_BAUD:  s_d.rdata = {7'h00, s_q.useGen};
                REG_T1:    s_d.rdata = s_q.t1Reload;
                REG_GENL:  s_d.rdata = s_q.genReload[7:0];
                REG_GENH:  s_d.rdata = {6'h00, s_q.genReload[9:8]};
                REG_ISTAT: s_d.rdata = {6'h00, s_q.intStat};
                REG_IMASK: s_d.rdata = {6'h00, s_q.intMask};
                default:   s_d.rdata = 8'h00;
            endcase
        end

        // line: idle high, start low, then shifter output
        s_d.txPin = !s_d.txActive ? 1'b1 : (!s_d.txDataEn ? 1'b0 : s_d.txShift[0]);
        s_d.irq   = |(s_d.intStat & s_d.intMask);
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_q           <= '0;
            s_q.genReload <= GEN_RELOAD_RST;
            s_q.rxState   <= RX_HUNT;
            s_q.rxLast    <= 1'b1;
            s_q.sync1     <= 1'b1;
            s_q.sync2     <= 1'b1;
            s_q.txPin     <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdData        = s_q.rdata;
    assign serial_tx_pin = s_q.txPin;
    assign irq           = s_q.irq;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    start_bit_low_a: assert property (
        (s_q.txActive && !s_q.txDataEn) |-> !serial_tx_pin)
        else $error("start bit not low on line");

    mode2_rate_a: assert property (
        (!s_q.mode3 && s_q.baudDouble) |-> tick16)
        else $error("mode 2 doubled rate missing tick");

    tx_on_roll_a: assert property (
        $rose(s_q.txActive) |-> $past(txRoll) && $past(s_q.txReq))
        else $error("send started off rollover");

    data_enable_a: assert property (
        (txRoll && s_q.txActive && !s_q.txDataEn) |=> s_q.txDataEn && s_q.txActive)
        else $error("data enable not one bit after start");

    start_line_a: assert property (
        $rose(s_q.txActive) |-> !s_q.txDataEn && !s_q.txShifted)
        else $error("send began with data already enabled");

    first_shift_a: assert property (
        (txRoll && s_q.txDataEn && !s_q.txShifted && s_q.txActive) |=> s_q.txShift[8] && s_q.txShifted)
        else $error("first shift did not insert stop bit");

    tx_done_set_a: assert property (
        $fell(s_q.txActive) |-> s_q.txDone && s_q.intStat[INT_TX] && serial_tx_pin)
        else $error("send end without done flag");

    rx_preload_a: assert property (
        startDetect |=> (s_q.rxShift == 9'h1FF) && (s_q.rxState == RX_BITS) && (s_q.rxCnt == 4'h1))
        else $error("start detect did not preload shifter");

    false_start_a: assert property (
        falseStart |=> (s_q.rxState == RX_HUNT) && !s_q.rxDone == !$past(s_q.rxDone))
        else $error("false start not rejected");

    reject_keep_a: assert property (
        (rxFinal && !rxAccept) |=> $stable(s_q.rxBuf) && $stable(s_q.rxNinth))
        else $error("rejected frame altered buffer");

    accept_load_a: assert property (
        rxAccept |=> s_q.rxDone && (s_q.rxNinth == $past(rxVote)))
        else $error("accepted frame not loaded");

    hold_bit_a: assert property (
        rxFinal |=> (s_q.rxState == RX_HOLD) && (s_q.rxCnt == SMP_C + 4'h1))
        else $error("receiver did not enter hold after final shift");

    hold_leave_a: assert property (
        ((s_q.rxState == RX_HOLD) && rxVoteNow) |=> (s_q.rxState == RX_HUNT))
        else $error("receiver did not return to hunting");

    hold_stay_a: assert property (
        ((s_q.rxState == RX_HOLD) && !rxVoteNow) |=> (s_q.rxState == RX_HOLD))
        else $error("receiver left hold before one bit time");

    flag_sticky_a: assert property (
        (s_q.rxDone && !ctrlWr) |=> s_q.rxDone)
        else $error("done flag cleared by hardware");

    tx_sticky_a: assert property (
        (s_q.txDone && !ctrlWr) |=> s_q.txDone)
        else $error("send done flag cleared by hardware");

    idle_line_a: assert property (
        !s_q.txActive |-> serial_tx_pin)
        else $error("line not idle high outside a frame");

    data_line_a: assert property (
        (s_q.txActive && s_q.txDataEn) |-> (serial_tx_pin == s_q.txShift[0]))
        else $error("line does not follow shifter output");

    tx_ninth_a: assert property (
        (busIn.wr && (busIn.addr == REG_BUF)) |=> (s_q.txShift[8] == $past(s_q.txNinth)) && s_q.txReq)
        else $error("buffer write did not load ninth bit");

    mode2_half_a: assert property (
        (!s_q.mode3 && !s_q.baudDouble && tick16) |=> !tick16 || s_q.baudDouble || s_q.mode3)
        else $error("mode 2 undoubled rate too fast");

    timer_source_a: assert property (
        (s_q.mode3 && !s_q.useGen && tick16) |-> t1Ovf)
        else $error("mode 3 tick without timer overflow");

    gen_source_a: assert property (
        (s_q.mode3 && s_q.useGen && tick16) |-> genOvf)
        else $error("mode 3 tick without generator overflow");

    hunt_start_a: assert property (
        ((s_q.rxState == RX_HUNT) && s_q.rxEn && tick16 && s_q.rxLast && !s_q.sync2) |=> (s_q.rxState == RX_BITS))
        else $error("falling edge not taken as start");

    sample_first_a: assert property (
        (tick16 && (s_q.rxState == RX_BITS) && (s_q.rxCnt == SMP_A)) |=> (s_q.smpA == $past(s_q.sync2)))
        else $error("first sample not taken at its state");

    majority_vote_a: assert property (
        rxVoteNow |-> (rxVote == (({1'b0, s_q.smpA} + {1'b0, s_q.smpB} + {1'b0, s_q.sync2}) >= 2'h2)))
        else $error("accepted value not two of three");

    shift_in_a: assert property (
        (rxVoteNow && (s_q.rxState == RX_BITS) && !s_q.rxFirst) |=> (s_q.rxShift == {$past(s_q.rxShift[7:0]), $past(rxVote)}))
        else $error("receive shifter did not shift left");

    filter_drop_a: assert property (
        (rxFinal && (s_q.rxDone || (s_q.mpFilter && !rxVote))) |-> !rxAccept)
        else $error("frame loaded despite load conditions");

    buffer_order_a: assert property (
        rxAccept |=> (s_q.rxBuf[0] == $past(s_q.rxShift[7])) && (s_q.rxBuf[7] == $past(s_q.rxShift[0])))
        else $error("received byte not least significant first");

    stop_ignored_a: assert property (
        (s_q.rxState == RX_HOLD) |=> $stable(s_q.rxBuf) && $stable(s_q.rxNinth))
        else $error("stop bit time altered received data");

endmodule // unb_serial

// File: tb/unb_remote_node.sv
module unb_remote_node (
    // clock
    input  wire logic clk,
    // serial lines seen from the far node
    input  wire logic txLine,
    output logic      rxLine
);
    timeunit 1ns;
    timeprecision 1ns;

    // idle mark level, as a pulled-up line
    initial rxLine = 1'b1;

    // one frame: start, data lsb first, ninth, stop; optional one-clock glitch mid bit
    task automatic sendFrame(input logic [7:0] d, input logic nine, input logic stopBit,
                             input int per, input logic glitch);
        logic [10:0] f;
        f = {stopBit, nine, d, 1'b0};
        repeat (per) @(posedge clk);
        for (int i = 0; i < 11; i++) begin
            for (int c = 0; c < per; c++) begin
                @(posedge clk);
                rxLine <= (glitch && c == per / 2) ? ~f[i] : f[i];
            end
        end
        @(posedge clk);
        rxLine <= 1'b1;
    endtask

    // short low pulse, too short for a start bit
    task automatic pulseLow(input int n);
        @(posedge clk);
        rxLine <= 1'b0;
        repeat (n) @(posedge clk);
        rxLine <= 1'b1;
    endtask

    // capture eleven bits at mid bit; ok low when no start edge came
    task automatic recvFrame(input int per, output logic [10:0] f, output logic ok);
        int n;
        n = 0;
        f = '0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (txLine && n < 4000);
        ok = !txLine;
        repeat (per / 2) @(posedge clk);
        #1;
        for (int i = 0; i < 11; i++) begin
            f[i] = txLine;
            if (i < 10) begin
                repeat (per) @(posedge clk);
                #1;
            end
        end
    endtask
endmodule // unb_remote_node

// File: tb/unb_serial_bench.sv
module unb_serial_bench
    import unb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic       core_clk;
    logic       rst;
    unb_bus_s   busIn;
    logic [7:0] rdData;
    logic       rxLine;
    logic       txLine;
    logic       irq;
    int         nFail;
    int         totalChecks;

    unb_serial unb_serial_i (
        .core_clk     (core_clk),
        .rst          (rst),
        .busIn        (busIn),
        .rdData       (rdData),
        .serial_rx_pin(rxLine),
        .serial_tx_pin(txLine),
        .irq          (irq)
    );

    unb_remote_node unb_remote_node_i (
        .clk   (core_clk),
        .txLine(txLine),
        .rxLine(rxLine)
    );

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic endOfTest;
        $display("checks=%0d mismatches=%0d", totalChecks, nFail);
        if (nFail == 0 && totalChecks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            nFail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic regWr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        busIn.wr    <= 1'b1;
        busIn.addr  <= a;
        busIn.wdata <= d;
        @(posedge core_clk);
        busIn.wr    <= 1'b0;
    endtask

    task automatic regRd(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        busIn.rd   <= 1'b1;
        busIn.addr <= a;
        @(posedge core_clk);
        busIn.rd   <= 1'b0;
        #1;
        d = rdData;
    endtask

    task automatic resetTest;
        logic [7:0] r;
        chk(txLine, 1'b1);
        chk(irq, 1'b0);
        regRd(REG_CTRL, r);
        chk(r, 8'h00);
        @(posedge core_clk);
        #1;
        chk(rdData, 8'h00);
        regWr(4'hC, 8'hFF);
        regRd(4'hC, r);
        chk(r, 8'h00);
        regRd(REG_IMASK, r);
        chk(r, 8'h00);
    endtask

    // one frame per bit-rate setting (mode 2 doubled and undoubled, timer 1, generator), each with the clocks per bit it gives
    task automatic txTest;
        logic [7:0]  ctl[4] = '{8'h08, 8'h00, 8'h48, 8'h40};
        logic [7:0]  pwr[4] = '{8'h80, 8'h00, 8'h80, 8'h80};
        logic [7:0]  dat[4] = '{8'hA5, 8'h3C, 8'h81, 8'h7E};
        int          per[4] = '{16, 32, 96, 32};
        logic [10:0] f;
        logic        ok;
        logic [7:0]  r;
        regWr(REG_T1, 8'hFF);
        regWr(REG_GENL, 8'hFE);
        regWr(REG_GENH, 8'h03);
        for (int k = 0; k < 4; k++) begin
            regWr(REG_CTRL, ctl[k]);
            regWr(REG_PWR, pwr[k]);
            regWr(REG_BAUD, {7'h00, k == 3});
            regWr(REG_BUF, dat[k]);
            unb_remote_node_i.recvFrame(per[k], f, ok);
            if (!ok) begin
                nFail++;
                endOfTest();
            end
            chk(f, {1'b1, ctl[k][3], dat[k], 1'b0});
            regRd(REG_CTRL, r);
            chk(r[1], 1'b1);
            regRd(REG_ISTAT, r);
            chk(r[0], 1'b1);
            chk(irq, 1'b0);
            regWr(REG_CTRL, ctl[k]);
            regWr(REG_ISTAT, 8'h01);
        end
    endtask

    task automatic rxTest;
        logic [7:0] r;
        regWr(REG_PWR, 8'h80);
        regWr(REG_IMASK, 8'h02);
        regWr(REG_CTRL, 8'h10);
        unb_remote_node_i.pulseLow(4);
        repeat (40) @(posedge core_clk);
        regRd(REG_CTRL, r);
        chk(r[0], 1'b0);
        // glitched bits and a bad stop bit still load
        unb_remote_node_i.sendFrame(8'h5A, 1'b1, 1'b0, 16, 1'b1);
        chk(irq, 1'b1);
        regRd(REG_BUF, r);
        chk(r, 8'h5A);
        // flag still set: next frame is lost
        unb_remote_node_i.sendFrame(8'hC3, 1'b1, 1'b1, 16, 1'b0);
        regRd(REG_BUF, r);
        chk(r, 8'h5A);
        regRd(REG_CTRL, r);
        chk(r[2:0], 3'b101);
        regWr(REG_CTRL, 8'h30);
        regWr(REG_ISTAT, 8'h02);
        #1;
        chk(irq, 1'b0);
        unb_remote_node_i.sendFrame(8'h33, 1'b0, 1'b1, 16, 1'b0);
        regRd(REG_CTRL, r);
        chk(r[0], 1'b0);
        unb_remote_node_i.sendFrame(8'h96, 1'b1, 1'b1, 16, 1'b0);
        regRd(REG_BUF, r);
        chk(r, 8'h96);
        regWr(REG_CTRL, 8'h10);
        unb_remote_node_i.sendFrame(8'h81, 1'b0, 1'b1, 16, 1'b0);
        regRd(REG_CTRL, r);
        chk(r[2:0], 3'b001);
        regRd(REG_BUF, r);
        chk(r, 8'h81);
    endtask

    initial begin
        nFail       = 0;
        totalChecks = 0;
        rst         = 1'b1;
        busIn       = '0;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        resetTest();
        txTest();
        rxTest();
        endOfTest();
    end
endmodule // unb_serial_bench
